// ===== verilog/slocp_core.sv
// second-level overcurrent protection and hiccup sequencer
// assumes a one-cycle switching-cycle boundary pulse from the oscillator on cycle_start_in, synchronous to clk_in,
// and asynchronous comparator levels for drain current and supply
`timescale 1ns/10ps
`include "slocp_cfg.svh"
module slocp_core
    import slocp_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic cycle_start_in,
    input wire logic over_max_current_in,
    input wire logic supply_undervoltage_in,
    input wire logic supply_below_restart_in,
    input wire logic supply_turn_on_in,
    output logic switch_enable_out,
    output logic startup_source_enable_out,
    output logic warning_out,
    output logic fault_latched_out
);
    typedef struct packed {
        slocp_state_t state;
        logic trip_sticky;
        logic switch_en;
        logic source_en;
        logic warn;
        logic latched;
    } slocp_core_t;
    slocp_core_t st_reg;
    slocp_core_t st_next;
    logic ocp_sync;
    logic uvlo_sync;
    logic restart_sync;
    logic turn_on_sync;
    logic cycle_trip;
    logic [`SLOCP_NUM_ASYNC-1:0] async_raw;
    logic [`SLOCP_NUM_ASYNC-1:0] async_level;

    // a boundary that closes a cycle in which the comparator tripped
    function automatic logic slocp_closed_trip(input logic boundary, input logic trip);
        return boundary && trip;
    endfunction

    // switch allowed only while running normally
    function automatic logic slocp_runs(input slocp_state_t s);
        return (s == SLOCP_ST_IDLE) || (s == SLOCP_ST_WARN);
    endfunction

    // startup source on while the supply capacitor is being charged
    function automatic logic slocp_charges(input slocp_state_t s);
        return (s == SLOCP_ST_CHARGE) || (s == SLOCP_ST_RECHARGE);
    endfunction

    // comparator levels gathered so one loop builds every synchroniser
    assign async_raw[`SLOCP_IDX_OCP] = over_max_current_in;
    assign async_raw[`SLOCP_IDX_UVLO] = supply_undervoltage_in;
    assign async_raw[`SLOCP_IDX_RESTART] = supply_below_restart_in;
    assign async_raw[`SLOCP_IDX_ON] = supply_turn_on_in;

    // each comparator crosses into the clock domain through its own chain;
    // a pulse caught by only one flop never reaches the state machine
    for (genvar i = 0; i < `SLOCP_NUM_ASYNC; i++) begin : g_sync
        slocp_sync u_sync (
            .clk_in(clk_in),
            .resetn_in(resetn_in),
            .async_in(async_raw[i]),
            .level_out(async_level[i])
        );
    end

    // named views of the filtered comparator levels
    assign ocp_sync = async_level[`SLOCP_IDX_OCP];
    assign uvlo_sync = async_level[`SLOCP_IDX_UVLO];
    assign restart_sync = async_level[`SLOCP_IDX_RESTART];
    assign turn_on_sync = async_level[`SLOCP_IDX_ON];

    // trip seen anywhere in the closing cycle, including its last clock
    assign cycle_trip = st_reg.trip_sticky | ocp_sync;

    // protection and hiccup sequencing
    always_comb begin
        st_next = st_reg;
        // sticky flag: set during the cycle, cleared at the boundary; clear wins
        if (cycle_start_in) begin
            st_next.trip_sticky = `SLOCP_ZERO;
        end else if (ocp_sync) begin
            st_next.trip_sticky = `SLOCP_ONE;
        end
        unique case (st_reg.state)
            SLOCP_ST_CHARGE: begin
                // supply charging from the startup source
                if (turn_on_sync) begin
                    st_next.state = SLOCP_ST_IDLE;
                end
            end
            SLOCP_ST_IDLE: begin
                if (uvlo_sync) begin
                    st_next.state = SLOCP_ST_WAIT_RESTART;
                end else if (slocp_closed_trip(cycle_start_in, cycle_trip)) begin
                    st_next.state = SLOCP_ST_WARN;
                end
            end
            SLOCP_ST_WARN: begin
                if (uvlo_sync) begin
                    st_next.state = SLOCP_ST_WAIT_RESTART;
                end else if (slocp_closed_trip(cycle_start_in, cycle_trip)) begin
                    st_next.state = SLOCP_ST_LATCHED;
                end else if (cycle_start_in) begin
                    st_next.state = SLOCP_ST_IDLE;
                end
            end
            SLOCP_ST_LATCHED: begin
                // held while supplied; only undervoltage releases it
                if (uvlo_sync) begin
                    st_next.state = SLOCP_ST_WAIT_RESTART;
                end
            end
            SLOCP_ST_WAIT_RESTART: begin
                if (restart_sync) begin
                    st_next.state = SLOCP_ST_RECHARGE;
                end
            end
            SLOCP_ST_RECHARGE: begin
                if (turn_on_sync) begin
                    st_next.state = SLOCP_ST_IDLE;
                end
            end
        endcase
        // registered outputs from the next state
        st_next.switch_en = slocp_runs(st_next.state);
        st_next.source_en = slocp_charges(st_next.state);
        st_next.warn = (st_next.state == SLOCP_ST_WARN);
        st_next.latched = (st_next.state == SLOCP_ST_LATCHED);
    end

    // registers; power-up starts charging the supply
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg.state <= SLOCP_ST_CHARGE;
            st_reg.trip_sticky <= `SLOCP_ZERO;
            st_reg.switch_en <= `SLOCP_ZERO;
            st_reg.source_en <= `SLOCP_ONE;
            st_reg.warn <= `SLOCP_ZERO;
            st_reg.latched <= `SLOCP_ZERO;
        end else begin
            st_reg <= st_next;
        end
    end

    assign switch_enable_out = st_reg.switch_en;
    assign startup_source_enable_out = st_reg.source_en;
    assign warning_out = st_reg.warn;
    assign fault_latched_out = st_reg.latched;
endmodule

// ===== inc/slocp_cfg.svh
// constants for the second-level overcurrent hiccup block
// assumes comparator inputs are asynchronous to clk_in
// Overview of operation
// - drain current above the maximum threshold feeds the protection logic as a fault event
// - first tripped cycle moves idle to warning, switch keeps running
// - warning plus a clean next cycle returns the logic to idle
// - trips in two back-to-back cycles declare a fault and force switch off
// - shutdown is latched while the supply stays present
// - supply undervoltage comparator clears the shutdown latch
// - after clear, startup source stays off until supply drops below restart level
// - switching resumes at turn-on level; persistent fault repeats the hiccup cycle
`ifndef SLOCP_CFG_SVH
`define SLOCP_CFG_SVH
`define SLOCP_SYNC_DEPTH 3
`define SLOCP_NUM_ASYNC 4
`define SLOCP_IDX_OCP 0
`define SLOCP_IDX_UVLO 1
`define SLOCP_IDX_RESTART 2
`define SLOCP_IDX_ON 3
`define SLOCP_ZERO 1'b0
`define SLOCP_ONE 1'b1
`endif

// ===== inc/slocp_pkg.sv
// types for the second-level overcurrent hiccup block
// assumes slocp_cfg.svh supplies the constants
package slocp_pkg;
    // protection and supply sequencing states, one-hot
    typedef enum logic [5:0] {
        SLOCP_ST_CHARGE = 6'h01,
        SLOCP_ST_IDLE = 6'h02,
        SLOCP_ST_WARN = 6'h04,
        SLOCP_ST_LATCHED = 6'h08,
        SLOCP_ST_WAIT_RESTART = 6'h10,
        SLOCP_ST_RECHARGE = 6'h20
    } slocp_state_t;
endpackage

// ===== verilog/slocp_sync.sv
// three-stage synchroniser with agreement filter
// assumes async level input, single clock clk_in
`timescale 1ns/10ps
`include "slocp_cfg.svh"
module slocp_sync (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic async_in,
    output logic level_out
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } slocp_sync_t;
    slocp_sync_t st_reg;
    slocp_sync_t st_next;

    // shift chain; level follows once stages two and three agree
    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.level = st_reg.s3;
        end
    end

    // registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.level;
endmodule

// ===== verification/slocp_checker.sv
// port assertions for the overcurrent hiccup block
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module slocp_checker (
    input wire logic clk_in, resetn_in, cycle_start_in, over_max_current_in,
    input wire logic supply_undervoltage_in, supply_below_restart_in, supply_turn_on_in,
    input wire logic switch_enable_out, startup_source_enable_out, warning_out, fault_latched_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    latch_off_a: assert property (fault_latched_out |-> !switch_enable_out)
        else $error("switch on while latched");
    warn_run_a: assert property (warning_out |-> switch_enable_out && !fault_latched_out)
        else $error("warning stopped the switch");
    warn_edge_a: assert property ($rose(warning_out) |-> $past(cycle_start_in) || $past(cycle_start_in, 2))
        else $error("warning away from boundary");
    latch_cause_a: assert property ($rose(fault_latched_out) |-> $past(warning_out))
        else $error("latch without warning");
    warn_clear_a: assert property ($fell(warning_out) |-> $past(cycle_start_in) || $past(cycle_start_in, 2)
        || $past(supply_undervoltage_in, 3)) else $error("warning left off boundary");
    latch_clear_a: assert property ($fell(fault_latched_out) |-> $past(supply_undervoltage_in, 3))
        else $error("latch cleared without undervoltage");
    src_wait_a: assert property ($rose(startup_source_enable_out) |-> $past(supply_below_restart_in, 3))
        else $error("source on above restart level");
    sw_resume_a: assert property ($rose(switch_enable_out) |-> $past(supply_turn_on_in, 3))
        else $error("switch on below turn-on level");
endmodule
bind slocp_core slocp_checker chk (.*);

// ===== verification/slocp_far.sv
// supply monitor and current comparator model
// assumes supply charges from the startup source and decays while stopped
`timescale 1ns/10ps
module slocp_far (
    input wire logic clk_in, switch_in, source_in, short_in,
    output logic over_out, uv_out, restart_out, on_out
);
    int vdd = 0;
    // supply level: charge, hold while switching, decay when stopped
    always @(negedge clk_in) begin
        if (source_in) vdd <= vdd + 1;
        else if (!switch_in && vdd > 0) vdd <= vdd - 1;
    end
    // comparator levels, off below on for hysteresis
    assign uv_out = vdd < 20;
    assign restart_out = vdd < 10;
    assign on_out = vdd >= 40;
    assign over_out = short_in && switch_in;
endmodule

// ===== verification/tb_second_level_ocp_hiccup_fsm.sv
// testbench for the overcurrent hiccup block
// assumes 100 MHz clock and a boundary pulse every 16 clocks
`timescale 1ns/10ps
module tb_second_level_ocp_hiccup_fsm;
    logic clk_in = 0, resetn_in = 0, cycle_start_in = 0, short_fault = 0;
    logic over_max_current_in, supply_undervoltage_in, supply_below_restart_in, supply_turn_on_in;
    logic switch_enable_out, startup_source_enable_out, warning_out, fault_latched_out;
    logic [3:0] phase = 4'h0;
    logic [3:0] outs;
    int bad_count = 0, checked = 0, ticks = 0;
    slocp_core uut (.*);
    slocp_far far (.clk_in(clk_in), .switch_in(switch_enable_out), .source_in(startup_source_enable_out),
        .short_in(short_fault), .over_out(over_max_current_in), .uv_out(supply_undervoltage_in),
        .restart_out(supply_below_restart_in), .on_out(supply_turn_on_in));
    assign outs = {fault_latched_out, warning_out, startup_source_enable_out, switch_enable_out};
    always #5 clk_in = ~clk_in;
    // boundary pulse and run ceiling
    always @(negedge clk_in) begin
        phase <= phase + 4'h1;
        cycle_start_in <= phase == 4'hf;
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            bad_count++;
            end_sim;
        end
    end
    task automatic check(input logic seen, input logic want);
        checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[FAIL] %0t seen %b want %b", $time, seen, want);
        end
    endtask
    task automatic wait_for(input int k, input logic v);
        for (int i = 0; i < 400 && outs[k] !== v; i++) @(negedge clk_in);
    endtask
    task automatic t_startup;
        wait_for(0, 1'h1);
        check(switch_enable_out, 1'h1);
        check(fault_latched_out, 1'h0);
        $display("startup done");
    endtask
    task automatic t_transient;
        while (phase != 4'h1) @(negedge clk_in);
        short_fault = 1'h1;
        repeat (3) @(negedge clk_in);
        short_fault = 1'h0;
        repeat (16) @(negedge clk_in);
        check(warning_out, 1'h1);
        check(switch_enable_out, 1'h1);
        repeat (16) @(negedge clk_in);
        check(warning_out, 1'h0);
        check(fault_latched_out, 1'h0);
        $display("transient done");
    endtask
    task automatic t_fault;
        while (phase != 4'h1) @(negedge clk_in);
        short_fault = 1'h1;
        wait_for(3, 1'h1);
        check(switch_enable_out, 1'h0);
        check(startup_source_enable_out, 1'h0);
        wait_for(3, 1'h0);
        check(fault_latched_out, 1'h0);
        check(startup_source_enable_out, 1'h0);
        wait_for(1, 1'h1);
        check(startup_source_enable_out, 1'h1);
        wait_for(0, 1'h1);
        check(switch_enable_out, 1'h1);
        wait_for(3, 1'h1);
        check(fault_latched_out, 1'h1);
        short_fault = 1'h0;
        $display("hiccup done");
    endtask
    task automatic end_sim;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_in);
        resetn_in = 1'h1;
        t_startup;
        t_transient;
        t_fault;
        end_sim;
    end
endmodule
